// ### hw/drs_regs.svh
// Functional notes
// - Dancer mode only when action select is 40, 41, 42 or 43.
// - PID_ACTIVE_FLAG correction is added to the active mode's main speed command.
// - Main speed ramps with second accel and decel times.
// - Input function 14 routes terminal to dancer enable; dancer runs only when on.
// - Without an enable terminal, action select alone enables dancer control.
// - Action select zero or enable off gives normal uncorrected operation.
// - Terminal 4 is never the main speed source in dancer mode.
// - Set point from setting; roller position from terminal 4.
// - Range 0: 4-20 mA, 1: 0-5 V, 2: 0-10 V, scaled 0-100%.
// - Upper flag while measured exceeds limit unless 9999; codes 15/115.
// - Lower flag while measured below limit unless 9999; codes 14/114.
// - Direction flag on for forward, off for reverse or stop; 16/116.
// - PID_ACTIVE_FLAG-active flag while dancer control runs; codes 47/147.
// - Output function codes 100 or more drive inverted logic.
// - Thermistor level not 9999 removes terminal 2 from main speed use.
// - Enable rise adopts output frequency; fall ends dancer at set frequency.
// - Values 42 and 43 scale correction by main speed ratio.
`ifndef DRS_REGS_SVH
`define DRS_REGS_SVH
`define DRS_ACT_FIRST 8'h28
`define DRS_ACT_LAST 8'h2b
`define DRS_ACT_RATIO_FIRST 8'h2a
`define DRS_IN_FUNC_ENABLE 8'h0e
`define DRS_OUT_FUNC_LOWER 8'h0e
`define DRS_OUT_FUNC_UPPER 8'h0f
`define DRS_OUT_FUNC_DIR 8'h10
`define DRS_OUT_FUNC_PID 8'h2f
`define DRS_OUT_FUNC_NEG 8'h64
`define DRS_NO_FUNCTION 14'h270f
`define DRS_PCT_FULL 11'h3e8
`define DRS_PCT_HALF 11'h1f4
`define DRS_RANGE_MA 2'h0
`define DRS_RANGE_5V 2'h1
`define DRS_RANGE_10V 2'h2
`define DRS_ADC_4MA 12'h333
`define DRS_K_MA 12'h4e2
`define DRS_K_5V 12'h7d0
`define DRS_K_10V 12'h3e8
`define DRS_RATIO_K 13'h0aec
`define DRS_CLK_PERIOD_NS 8
`define DRS_RAMP_STEP_NS 16667
`define DRS_RAMP_STEP_CYC ((`DRS_RAMP_STEP_NS + `DRS_CLK_PERIOD_NS - 1) / `DRS_CLK_PERIOD_NS)
`endif

// ### hw/drs_pkg.sv
package drs_pkg;
  typedef enum logic [1:0] {
    DRS_ST_NORMAL = 2'b01,
    DRS_ST_DANCER = 2'b10
  } drs_state_e;
  typedef enum logic [1:0] {
    DRS_MODE_EXT = 2'h0,
    DRS_MODE_PANEL = 2'h1,
    DRS_MODE_NET = 2'h2
  } drs_mode_e;
  typedef enum logic [1:0] {
    DRS_SRC_T2 = 2'h0,
    DRS_SRC_T4 = 2'h1,
    DRS_SRC_MULTI = 2'h2
  } drs_src_e;
  typedef struct packed {
    logic upper;
    logic lower;
    logic forward;
    logic pid_active_flag;
  } drs_flags_s;
endpackage : drs_pkg

// ### hw/drs_flags_if.sv
`timescale 1ns/1ps
interface drs_flags_if;
  drs_pkg::drs_flags_s flags;
  modport src (output flags);
  modport dst (input flags);
endinterface : drs_flags_if

// ### hw/drs_out_map.sv
`timescale 1ns/1ps
`include "drs_regs.svh"
module drs_out_map (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] func_code,
  drs_flags_if.dst fl,
  output logic term_out
);
  logic term_reg;
  logic term_next;
  logic [7:0] base;
  logic sel;
  always_comb
  begin
    base = (func_code >= `DRS_OUT_FUNC_NEG) ? func_code - `DRS_OUT_FUNC_NEG : func_code;
    if (base == `DRS_OUT_FUNC_UPPER)
      sel = fl.flags.upper;
    else if (base == `DRS_OUT_FUNC_LOWER)
      sel = fl.flags.lower;
    else if (base == `DRS_OUT_FUNC_DIR)
      sel = fl.flags.forward;
    else if (base == `DRS_OUT_FUNC_PID)
      sel = fl.flags.pid_active_flag;
    else
      sel = 1'b0;
    term_next = (func_code >= `DRS_OUT_FUNC_NEG) ? ~sel : sel;
  end
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      term_reg <= 1'b0;
    else
      term_reg <= term_next;
  end
  assign term_out = term_reg;
  AST_NEG_LOGIC: assert property (@(posedge clk_sys) disable iff (!rstn)
    (func_code >= `DRS_OUT_FUNC_NEG && base == `DRS_OUT_FUNC_PID && $stable(func_code))
    |=> term_out == !$past(fl.flags.pid_active_flag))
    else $error("negative logic output not inverted");
endmodule : drs_out_map

// ### hw/drs_trim.sv
`timescale 1ns/1ps
`include "drs_regs.svh"
module drs_trim #(
  parameter int RAMP_STEP_CYC = `DRS_RAMP_STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] action_select_setting,
  input wire logic [4:0][7:0] input_terminal_function_settings,
  input wire logic [4:0] input_terminals,
  input wire logic [13:0] set_point_setting,
  input wire logic [1:0] input_range_setting,
  input wire logic [11:0] terminal4_adc,
  input wire logic [13:0] upper_limit_setting,
  input wire logic [13:0] lower_limit_setting,
  input wire logic [13:0] thermistor_level_setting,
  input wire logic [15:0] second_accel_time,
  input wire logic [15:0] second_decel_time,
  input wire logic [1:0] operation_mode,
  input wire logic [1:0] ext_source_select,
  input wire logic [15:0] terminal2_speed,
  input wire logic [15:0] terminal4_speed,
  input wire logic [15:0] multi_speed,
  input wire logic [15:0] panel_speed,
  input wire logic [15:0] network_speed,
  input wire logic [15:0] output_frequency,
  input wire logic running,
  input wire logic forward_running,
  input wire logic signed [15:0] pid_correction,
  input wire logic [7:0] output_terminal_function_a,
  input wire logic [7:0] output_terminal_function_b,
  input wire logic [7:0] output_terminal_function_c,
  output logic [15:0] speed_command,
  output logic [10:0] pid_set_point,
  output logic [10:0] pid_measured,
  output logic dancer_active,
  output logic output_terminal_a,
  output logic output_terminal_b,
  output logic output_terminal_c
);
  drs_pkg::drs_state_e state_reg, state_next;
  logic [15:0] main_reg, main_next;
  logic [27:0] cnt_reg, cnt_next;
  logic [15:0] cmd_reg, cmd_next;
  logic [10:0] sp_reg, sp_next;
  logic [10:0] meas_reg, meas_next;
  drs_pkg::drs_flags_s flags_reg, flags_next;
  logic en_assigned;
  logic en_in;
  logic act_ok;
  logic want;
  logic [15:0] target;
  logic [27:0] interval;
  logic [23:0] prod;
  logic [12:0] offs;
  logic signed [31:0] corr_w;
  logic signed [17:0] corr;
  logic signed [17:0] sum;
  drs_flags_if fl_if ();

  always_comb
  begin
    en_assigned = 1'b0;
    en_in = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      if (input_terminal_function_settings[i] == `DRS_IN_FUNC_ENABLE)
      begin
        en_assigned = 1'b1;
        en_in = en_in | input_terminals[i];
      end
    end
    act_ok = action_select_setting >= `DRS_ACT_FIRST && action_select_setting <= `DRS_ACT_LAST;
    want = act_ok && (!en_assigned || en_in);
  end

  always_comb
  begin
    target = 16'h0000;
    if (operation_mode == drs_pkg::DRS_MODE_PANEL)
      target = panel_speed;
    else if (operation_mode == drs_pkg::DRS_MODE_NET)
      target = network_speed;
    else if (ext_source_select == drs_pkg::DRS_SRC_MULTI)
      target = multi_speed;
    else if (ext_source_select == drs_pkg::DRS_SRC_T4 && !want)
      target = terminal4_speed;
    else if (thermistor_level_setting == `DRS_NO_FUNCTION)
      target = terminal2_speed;
    // terminal 4 refused in dancer mode, falls to terminal 2 above while thermistor level is 9999, else zero
  end

  always_comb
  begin
    state_next = state_reg;
    main_next = main_reg;
    cnt_next = cnt_reg;
    interval = 28'h0000000;
    case (state_reg)
      drs_pkg::DRS_ST_NORMAL:
      begin
        main_next = target;
        cnt_next = 28'h0000000;
        if (want)
        begin
          state_next = drs_pkg::DRS_ST_DANCER;
          if (running)
            main_next = output_frequency;
        end
      end
      drs_pkg::DRS_ST_DANCER:
      begin
        interval = (main_reg < target) ? 28'(second_accel_time * RAMP_STEP_CYC)
                                       : 28'(second_decel_time * RAMP_STEP_CYC);
        if (main_reg == target)
          cnt_next = 28'h0000000;
        else if (cnt_reg + 28'h0000001 >= interval)
        begin
          cnt_next = 28'h0000000;
          main_next = (main_reg < target) ? main_reg + 16'h0001 : main_reg - 16'h0001;
        end
        else
          cnt_next = cnt_reg + 28'h0000001;
        if (!want)
        begin
          state_next = drs_pkg::DRS_ST_NORMAL;
          main_next = target;
        end
      end
      default:
        state_next = drs_pkg::DRS_ST_NORMAL;
    endcase
  end

  always_comb
  begin
    corr_w = (32'(pid_correction) * 32'(signed'({1'b0, main_reg}))) * 32'(signed'(`DRS_RATIO_K));
    if (action_select_setting >= `DRS_ACT_RATIO_FIRST)
      corr = 18'(corr_w >>> 24);
    else
      corr = 18'(pid_correction);
    sum = 18'(signed'({2'b00, main_reg})) + corr;
    if (state_reg != drs_pkg::DRS_ST_DANCER || !want)
      cmd_next = target;
    else if (sum < 0)
      cmd_next = 16'h0000;
    else if (sum > 18'sh0ffff)
      cmd_next = 16'hffff;
    else
      cmd_next = sum[15:0];
  end

  always_comb
  begin
    offs = 13'h0000;
    prod = 24'h000000;
    if (input_range_setting == `DRS_RANGE_MA)
    begin
      offs = (terminal4_adc > `DRS_ADC_4MA) ? 13'(terminal4_adc - `DRS_ADC_4MA) : 13'h0000;
      prod = 24'(offs * `DRS_K_MA);
    end
    else if (input_range_setting == `DRS_RANGE_5V)
      prod = 24'(terminal4_adc * `DRS_K_5V);
    else
      prod = 24'(terminal4_adc * `DRS_K_10V);
    meas_next = (prod[23:12] > 12'(`DRS_PCT_FULL)) ? `DRS_PCT_FULL : prod[22:12];
    sp_next = (set_point_setting == `DRS_NO_FUNCTION) ? `DRS_PCT_HALF : set_point_setting[10:0];
    flags_next.upper = upper_limit_setting != `DRS_NO_FUNCTION && act_ok &&
                       14'(meas_next) > upper_limit_setting;
    flags_next.lower = lower_limit_setting != `DRS_NO_FUNCTION && act_ok &&
                       14'(meas_next) < lower_limit_setting;
    flags_next.forward = running && forward_running;
    flags_next.pid_active_flag = state_next == drs_pkg::DRS_ST_DANCER;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= drs_pkg::DRS_ST_NORMAL;
      main_reg <= 16'h0000;
      cnt_reg <= 28'h0000000;
      cmd_reg <= 16'h0000;
      sp_reg <= 11'h000;
      meas_reg <= 11'h000;
      flags_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      main_reg <= main_next;
      cnt_reg <= cnt_next;
      cmd_reg <= cmd_next;
      sp_reg <= sp_next;
      meas_reg <= meas_next;
      flags_reg <= flags_next;
    end
  end

  assign fl_if.flags = flags_reg;
  assign speed_command = cmd_reg;
  assign pid_set_point = sp_reg;
  assign pid_measured = meas_reg;
  assign dancer_active = flags_reg.pid_active_flag;

  drs_out_map u_map_a (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .func_code(output_terminal_function_a),
    .fl(fl_if.dst),
    .term_out(output_terminal_a)
  );
  drs_out_map u_map_b (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .func_code(output_terminal_function_b),
    .fl(fl_if.dst),
    .term_out(output_terminal_b)
  );
  drs_out_map u_map_c (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .func_code(output_terminal_function_c),
    .fl(fl_if.dst),
    .term_out(output_terminal_c)
  );

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_ACT_RANGE: assert property (dancer_active |-> $past(act_ok))
    else $error("dancer active outside action range");
  AST_ENABLE_INPUT: assert property ((en_assigned && !en_in) |=> !dancer_active)
    else $error("dancer active with enable input off");
  AST_NO_ENABLE_TERM: assert property ((!en_assigned && act_ok) |=> dancer_active)
    else $error("dancer not entered from action select alone");
  AST_NORMAL_CMD: assert property ((action_select_setting == 8'h00) |=> speed_command == $past(target))
    else $error("normal command not equal to target");
  AST_NO_T4: assert property ((want && operation_mode == drs_pkg::DRS_MODE_EXT &&
    ext_source_select == drs_pkg::DRS_SRC_T4) |-> target != terminal4_speed || target == terminal2_speed)
    else $error("terminal 4 used as main speed");
  AST_UPPER_OFF: assert property ((upper_limit_setting == `DRS_NO_FUNCTION) |=> !flags_reg.upper)
    else $error("upper flag set while disabled");
  AST_UPPER_ON: assert property ((act_ok && upper_limit_setting != `DRS_NO_FUNCTION &&
    14'(meas_next) > upper_limit_setting) |=> flags_reg.upper)
    else $error("upper flag missing");
  AST_LOWER_ON: assert property ((act_ok && lower_limit_setting != `DRS_NO_FUNCTION &&
    14'(meas_next) < lower_limit_setting) |=> flags_reg.lower)
    else $error("lower flag missing");
  AST_ADOPT: assert property ((state_reg == drs_pkg::DRS_ST_NORMAL && want && running)
    |=> main_reg == $past(output_frequency))
    else $error("output frequency not adopted");
  AST_THERM: assert property ((thermistor_level_setting != `DRS_NO_FUNCTION &&
    operation_mode == drs_pkg::DRS_MODE_EXT && ext_source_select == drs_pkg::DRS_SRC_T2)
    |-> target == 16'h0000)
    else $error("terminal 2 used with thermistor");
  AST_RAMP_STEP: assert property ((state_reg == drs_pkg::DRS_ST_DANCER && want)
    |=> (main_reg - $past(main_reg) <= 16'h0001) || ($past(main_reg) - main_reg <= 16'h0001))
    else $error("main speed ramp jumped");
  COV_ENTER: cover property (state_reg == drs_pkg::DRS_ST_NORMAL ##1 state_reg == drs_pkg::DRS_ST_DANCER);
  COV_LEAVE: cover property (state_reg == drs_pkg::DRS_ST_DANCER ##1 state_reg == drs_pkg::DRS_ST_NORMAL);
  COV_UPPER: cover property (flags_reg.upper);
  COV_RATIO: cover property (dancer_active && action_select_setting == 8'h2b);
endmodule : drs_trim

// ### verification/drs_detector.sv
`timescale 1ns/1ps
module drs_detector (
  input wire logic [10:0] position,
  input wire logic [1:0] range,
  input wire logic enable_on,
  output logic [11:0] adc_code,
  output logic [4:0] terminals
);
  always_comb
  begin
    case (range)
      2'h0: adc_code = 12'(32'd819 + 32'(position) * 32'd4096 / 32'd1250);
      2'h1: adc_code = 12'(32'(position) * 32'd4096 / 32'd2000);
      default: adc_code = 12'(32'(position) * 32'd4096 / 32'd1000);
    endcase
  end
  assign terminals = {enable_on, 4'h0};
endmodule : drs_detector

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] action_select_setting = 8'h00;
  logic [4:0][7:0] input_terminal_function_settings = '0;
  logic [4:0] input_terminals;
  logic [13:0] set_point_setting = 14'h270f, upper_limit_setting = 14'h270f;
  logic [13:0] lower_limit_setting = 14'h270f, thermistor_level_setting = 14'h270f;
  logic [1:0] input_range_setting = 2'h2, operation_mode = 2'h1, ext_source_select = 2'h0;
  logic [11:0] terminal4_adc;
  logic [15:0] second_accel_time = 16'h0000, second_decel_time = 16'h0000;
  logic [15:0] terminal2_speed = 16'h0a28, terminal4_speed = 16'h0fa0;
  logic [15:0] multi_speed = 16'h07d0, panel_speed = 16'h0bb8;
  logic [15:0] network_speed = 16'h03e8, output_frequency = 16'h0bb8;
  logic running = 1'b1, forward_running = 1'b1;
  logic signed [15:0] pid_correction = 16'sh0064;
  logic [7:0] output_terminal_function_a = 8'h0f, output_terminal_function_b = 8'h72;
  logic [7:0] output_terminal_function_c = 8'h10;
  logic [15:0] speed_command;
  logic [10:0] pid_set_point, pid_measured;
  logic dancer_active, output_terminal_a, output_terminal_b, output_terminal_c;
  logic [10:0] position = 11'h1f4;
  logic enable_on = 1'b0;
  int n_fail = 0;
  int total_checks = 0;
  logic [1:0] md [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
  logic [1:0] sel [4] = '{2'h0, 2'h2, 2'h0, 2'h0};
  logic [15:0] ex [4] = '{16'h0a28, 16'h07d0, 16'h0bb8, 16'h03e8};
  logic [1:0] rg [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
  logic [10:0] ps [4] = '{11'h271, 11'h1f4, 11'h1f4, 11'h5dc};
  logic [10:0] pm [4] = '{11'h271, 11'h1f4, 11'h1f4, 11'h3e8};
  logic [10:0] lp [3] = '{11'h2bc, 11'h1f4, 11'h12c};

  always #4 clk_sys = ~clk_sys;

  drs_trim #(.RAMP_STEP_CYC(2)) dut_u (.clk_sys, .rstn, .action_select_setting,
    .input_terminal_function_settings, .input_terminals, .set_point_setting,
    .input_range_setting, .terminal4_adc, .upper_limit_setting, .lower_limit_setting,
    .thermistor_level_setting, .second_accel_time, .second_decel_time, .operation_mode,
    .ext_source_select, .terminal2_speed, .terminal4_speed, .multi_speed, .panel_speed,
    .network_speed, .output_frequency, .running, .forward_running, .pid_correction,
    .output_terminal_function_a, .output_terminal_function_b, .output_terminal_function_c,
    .speed_command, .pid_set_point, .pid_measured, .dancer_active, .output_terminal_a,
    .output_terminal_b, .output_terminal_c);

  drs_detector det_u (.position, .range(input_range_setting), .enable_on,
    .adc_code(terminal4_adc), .terminals(input_terminals));

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_speed(input logic [15:0] exp, input int lim);
    int i;
    for (i = 0; i < lim && speed_command !== exp; i++)
      step(1);
    chk(speed_command, exp);
  endtask : wait_speed

  task automatic test_done;
    $display("Checks %0d, errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  initial
  begin
    step(3);
    chk(speed_command, 16'h0000);
    chk(16'(output_terminal_b), 16'h0000);
    rstn = 1'b1;
    step(2);
    for (int k = 0; k < 4; k++)
    begin
      operation_mode = md[k];
      ext_source_select = sel[k];
      step(2);
      chk(speed_command, ex[k]);
      chk(16'(dancer_active), 16'h0000);
    end
    operation_mode = 2'h1;
    for (int a = 39; a <= 44; a++)
    begin
      action_select_setting = 8'(a);
      step(3);
      chk(16'(dancer_active), 16'(a >= 40 && a <= 43));
      if (a == 41)
        chk(speed_command, 16'h0c1c);
      if (a == 43)
        chk(16'(speed_command >= 16'h0be9 && speed_command <= 16'h0bea), 16'h0001);
      action_select_setting = 8'h00;
      step(2);
      chk(speed_command, 16'h0bb8);
    end
    action_select_setting = 8'h29;
    step(2);
    chk(16'(pid_set_point), 16'h01f4);
    set_point_setting = 14'h00fa;
    step(2);
    chk(16'(pid_set_point), 16'h00fa);
    for (int k = 0; k < 4; k++)
    begin
      input_range_setting = rg[k];
      position = ps[k];
      step(2);
      chk(16'(pid_measured), 16'(pm[k]));
    end
    input_range_setting = 2'h2;
    upper_limit_setting = 14'h0258;
    lower_limit_setting = 14'h0190;
    for (int k = 0; k < 3; k++)
    begin
      position = lp[k];
      step(3);
      chk(16'(output_terminal_a), 16'(k == 0));
      chk(16'(output_terminal_b), 16'(k != 2));
    end
    upper_limit_setting = 14'h270f;
    lower_limit_setting = 14'h270f;
    position = 11'h000;
    step(3);
    chk(16'(output_terminal_a), 16'h0000);
    chk(16'(output_terminal_b), 16'h0001);
    chk(16'(output_terminal_c), 16'h0001);
    forward_running = 1'b0;
    step(3);
    chk(16'(output_terminal_c), 16'h0000);
    running = 1'b0;
    forward_running = 1'b1;
    step(3);
    chk(16'(output_terminal_c), 16'h0000);
    running = 1'b1;
    output_terminal_function_c = 8'h93;
    step(3);
    chk(16'(output_terminal_c), 16'h0000);
    output_terminal_function_c = 8'h2f;
    step(3);
    chk(16'(output_terminal_c), 16'h0001);
    input_terminal_function_settings[4] = 8'h0e;
    step(3);
    chk(16'(dancer_active), 16'h0000);
    chk(speed_command, 16'h0bb8);
    chk(16'(output_terminal_c), 16'h0000);
    second_accel_time = 16'h0005;
    output_frequency = 16'h0b54;
    enable_on = 1'b1;
    step(3);
    chk(16'(dancer_active), 16'h0001);
    chk(speed_command, 16'h0bb8);
    step(50);
    chk(16'(speed_command < 16'h0c1c && speed_command > 16'h0bb8), 16'h0001);
    wait_speed(16'h0c1c, 3000);
    enable_on = 1'b0;
    step(2);
    chk(16'(dancer_active), 16'h0000);
    chk(speed_command, 16'h0bb8);
    input_terminal_function_settings[4] = 8'h00;
    second_accel_time = 16'h0000;
    output_frequency = 16'h0bb8;
    operation_mode = 2'h0;
    ext_source_select = 2'h1;
    step(2);
    wait_speed(16'h0a8c, 2000);
    thermistor_level_setting = 14'h0064;
    wait_speed(16'h0064, 5000);
    action_select_setting = 8'h00;
    ext_source_select = 2'h0;
    step(2);
    chk(speed_command, 16'h0000);
    test_done();
  end
endmodule : tb
